//--- hw/ddl_latch_control.sv
`timescale 1ns/1ns
`default_nettype none
module ddl_latch_control (
  // Core clock
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  // Configuration
  input wire logic self_term,
  // Converter side
  output logic [ddl_pkg::CODE_W-1:0] latch_a_code,
  output logic [ddl_pkg::CODE_W-1:0] latch_b_code,
  output logic [ddl_pkg::CODE_W-1:0] double_buffer_code,
  output logic fast_mode,
  output logic power_down,
  output logic update_pulse
);
  logic [ddl_pkg::WORD_W-1:0] link_word;
  logic link_toggle;
  logic [ddl_pkg::WORD_W-1:0] word_sync;
  logic cs_sync;
  logic tog_sync;
  logic self_term_sync;
  logic cs_sync_d_reg;
  logic tog_sync_d_reg;
  logic frame_done_reg;
  logic [ddl_pkg::WORD_W-1:0] word_hold_reg;
  logic [1:0] settle_reg;
  logic [ddl_pkg::CODE_W-1:0] latch_a_reg;
  logic [ddl_pkg::CODE_W-1:0] latch_b_reg;
  logic [ddl_pkg::CODE_W-1:0] buf_reg;
  logic fast_reg;
  logic pd_reg;
  logic upd_reg;
  logic [1:0] arm_reg;

  ddl_shift_port u_port (
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .self_term(self_term),
    .shift_word_register(link_word),
    .frame_toggle(link_toggle)
  );

  // Word is stable while select is high or after self-termination
  ddl_sync #(.WIDTH(ddl_pkg::WORD_W + 3)) u_sync (
    .clk(ref_clk),
    .reset(reset),
    .enable(clk_en),
    .async_in({link_word, cs_n, link_toggle, self_term}),
    .sync_out({word_sync, cs_sync, tog_sync, self_term_sync})
  );

  function automatic ddl_pkg::ddl_xfer_t decode_xfer(input logic [ddl_pkg::WORD_W-1:0] w);
    if (w[ddl_pkg::LATCH_A_SELECT_BIT]) begin
      decode_xfer = ddl_pkg::DDL_XFER_A_WRITE;
    end else if (w[ddl_pkg::BUFFER_ONLY_BIT]) begin
      decode_xfer = ddl_pkg::DDL_XFER_BUF_ONLY;
    end else begin
      decode_xfer = ddl_pkg::DDL_XFER_B_WRITE;
    end
  endfunction

  // Synchronisers clear to zero whatever the pins hold; their first edges are not frames
  wire armed = arm_reg == 2'h3;
  wire cs_rise = armed && cs_sync && ~cs_sync_d_reg;
  wire cs_fall = armed && ~cs_sync && cs_sync_d_reg;
  wire tog_evt = armed && (tog_sync ^ tog_sync_d_reg);
  // Whichever end of frame arrives first wins; the other is swallowed
  wire end_evt = (cs_rise || (self_term_sync && tog_evt)) && ~frame_done_reg;
  wire fire = clk_en && settle_reg == 2'h1;
  wire ddl_pkg::ddl_xfer_t xfer = decode_xfer(word_hold_reg);
  wire [ddl_pkg::CODE_W-1:0] code = word_hold_reg[ddl_pkg::CODE_W-1:0];

  // Word bus bits may skew through the synchroniser; wait one more cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cs_sync_d_reg <= 1'b1;
      tog_sync_d_reg <= 1'b0;
      frame_done_reg <= 1'b0;
      settle_reg <= 2'h0;
      word_hold_reg <= ddl_pkg::WORD_RESET;
      arm_reg <= 2'h0;
    end else if (clk_en) begin
      if (!armed) begin
        arm_reg <= arm_reg + 2'h1;
      end
      cs_sync_d_reg <= cs_sync;
      tog_sync_d_reg <= tog_sync;
      if (cs_fall) begin
        frame_done_reg <= 1'b0;
      end else if (end_evt) begin
        frame_done_reg <= 1'b1;
      end
      if (end_evt) begin
        settle_reg <= 2'h2;
      end else if (settle_reg != 2'h0) begin
        settle_reg <= settle_reg - 2'h1;
      end
      if (settle_reg == 2'h2) begin
        word_hold_reg <= word_sync;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latch_a_reg <= ddl_pkg::CODE_RESET;
      latch_b_reg <= ddl_pkg::CODE_RESET;
      buf_reg <= ddl_pkg::CODE_RESET;
      fast_reg <= 1'b0;
      pd_reg <= 1'b0;
      upd_reg <= 1'b0;
    end else if (clk_en) begin
      upd_reg <= fire;
      if (fire) begin
        fast_reg <= word_hold_reg[ddl_pkg::SPEED_SELECT_BIT];
        pd_reg <= word_hold_reg[ddl_pkg::POWER_DOWN_BIT];
        case (xfer)
          ddl_pkg::DDL_XFER_A_WRITE: begin
            latch_a_reg <= code;
            latch_b_reg <= buf_reg;
          end
          ddl_pkg::DDL_XFER_B_WRITE: begin
            latch_b_reg <= code;
            buf_reg <= code;
          end
          ddl_pkg::DDL_XFER_BUF_ONLY: begin
            buf_reg <= code;
          end
          default: begin
            buf_reg <= buf_reg;
          end
        endcase
      end
    end
  end

  assign latch_a_code = latch_a_reg;
  assign latch_b_code = latch_b_reg;
  assign double_buffer_code = buf_reg;
  assign fast_mode = fast_reg;
  assign power_down = pd_reg;
  assign update_pulse = upd_reg;
endmodule
`default_nettype wire

//--- hw/ddl_pkg.sv
package ddl_pkg;
  localparam int WORD_W = 16;
  localparam int CODE_W = 12;
  localparam int CNT_W = 5;
  localparam int LATCH_A_SELECT_BIT = 15;
  localparam int SPEED_SELECT_BIT = 14;
  localparam int POWER_DOWN_BIT = 13;
  localparam int BUFFER_ONLY_BIT = 12;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    DDL_XFER_NONE,
    DDL_XFER_A_WRITE,
    DDL_XFER_B_WRITE,
    DDL_XFER_BUF_ONLY
  } ddl_xfer_t;
endpackage

//--- hw/ddl_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ddl_sync #(
  parameter int WIDTH = 1
) (
  // Clock
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else if (enable) begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end
  assign sync_out = stage2_reg;
endmodule
`default_nettype wire

//--- hw/ddl_shift_port.sv
`timescale 1ns/1ns
`default_nettype none
module ddl_shift_port (
  // Link clock domain
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic self_term,
  // Word and frame toggle into the core domain
  output logic [ddl_pkg::WORD_W-1:0] shift_word_register,
  output logic frame_toggle
);
  // No reset reaches the link side; power-up values only
  logic [ddl_pkg::CNT_W-1:0] bit_cnt_reg = '0;
  logic [ddl_pkg::CNT_W-1:0] bit_cnt_next;
  logic [ddl_pkg::WORD_W-1:0] word_next;
  logic [ddl_pkg::WORD_W-1:0] word_reg = ddl_pkg::WORD_RESET;
  logic toggle_reg = 1'b0;
  logic cs_seen_reg;
  logic counted_out;
  logic shift_en;

  // Frame restart is seen at the first falling edge after select drops
  wire frame_start = ~cs_seen_reg;
  wire [ddl_pkg::CNT_W-1:0] cnt_base = frame_start ? '0 : bit_cnt_reg;
  assign counted_out = self_term && (cnt_base == ddl_pkg::FRAME_BITS);
  assign shift_en = ~cs_n && ~counted_out;
  assign word_next = {word_reg[ddl_pkg::WORD_W-2:0], din};
  assign bit_cnt_next = (cnt_base == ddl_pkg::FRAME_BITS) ? cnt_base
                        : cnt_base + 5'h01;

  // Link clock may stop between frames, so cs_seen is cleared by select itself
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cs_seen_reg <= 1'b0;
    end else begin
      cs_seen_reg <= 1'b1;
    end
  end

  always_ff @(negedge sclk) begin
    if (shift_en) begin
      word_reg <= word_next;
      bit_cnt_reg <= bit_cnt_next;
    end else if (~cs_n) begin
      bit_cnt_reg <= cnt_base;
    end
  end

  // Internal end of frame: toggle at the sixteenth falling edge
  always_ff @(negedge sclk) begin
    if (shift_en && self_term && bit_cnt_next == ddl_pkg::FRAME_BITS) begin
      toggle_reg <= ~toggle_reg;
    end
  end

  assign shift_word_register = word_reg;
  assign frame_toggle = toggle_reg;
endmodule
`default_nettype wire

//--- testbench/ddl_latch_control_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module ddl_latch_control_monitor (
  // Core side
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic self_term,
  // Converter side
  input wire logic [ddl_pkg::CODE_W-1:0] latch_a_code,
  input wire logic [ddl_pkg::CODE_W-1:0] latch_b_code,
  input wire logic [ddl_pkg::CODE_W-1:0] double_buffer_code,
  input wire logic fast_mode,
  input wire logic power_down,
  input wire logic update_pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  pulse_single_a: assert property (update_pulse |=> !update_pulse)
    else $error("update pulse too long");
  change_pulse_a: assert property (
    !$stable({latch_a_code, latch_b_code, double_buffer_code}) |-> update_pulse)
    else $error("latch change without pulse");
  after_select_a: assert property (update_pulse && !self_term |-> $past(cs_n, 4))
    else $error("transfer before select rise");
  b_from_buf_a: assert property (
    update_pulse && latch_b_code != $past(latch_b_code) |-> latch_b_code == double_buffer_code)
    else $error("latch b differs from buffer");
  buf_keeps_a_a: assert property (
    update_pulse && double_buffer_code != $past(double_buffer_code) |-> $stable(latch_a_code))
    else $error("latch a moved on buffer write");
  a_keeps_buf_a: assert property (
    update_pulse && latch_a_code != $past(latch_a_code) |-> $stable(double_buffer_code))
    else $error("buffer moved on latch a write");
  mode_pulse_a: assert property ($changed({fast_mode, power_down}) |-> update_pulse)
    else $error("mode change without transfer");
  reset_clear_a: assert property (disable iff (1'b0) reset |=>
    {latch_a_code, latch_b_code, double_buffer_code, fast_mode, power_down} == '0)
    else $error("outputs not cleared by reset");
endmodule
bind ddl_latch_control ddl_latch_control_monitor u_mon (.ref_clk(ref_clk), .reset(reset),
  .cs_n(cs_n), .self_term(self_term), .latch_a_code(latch_a_code),
  .latch_b_code(latch_b_code), .double_buffer_code(double_buffer_code),
  .fast_mode(fast_mode), .power_down(power_down), .update_pulse(update_pulse));
`default_nettype wire

//--- testbench/ddl_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module ddl_host_model (
  // Serial link
  output var logic sclk,
  output var logic cs_n,
  output var logic din
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // MSB first at the fastest legal rate, clock parked high; data inverted once released
  task automatic send(input logic [19:0] w, input int n);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #10 din = w[i];
      #15 sclk = 1'b0;
      #25 sclk = 1'b1;
    end
    #10 cs_n = 1'b1;
    din = ~din;
  endtask
  // Clock runs with select high; the shifter must not move
  task automatic idle_clk(input int n);
    din = 1'b1;
    for (int i = 0; i < n; i++) begin
      #25 sclk = 1'b0;
      #25 sclk = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

//--- testbench/ddl_latch_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module ddl_latch_control_bench;
  logic ref_clk, reset, self_term;
  wire logic sclk, cs_n, din;
  logic [11:0] a, b, d;
  logic fast, pd, upd;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int pulses = 0;
  ddl_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din));
  ddl_latch_control dut (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .sclk(sclk),
    .cs_n(cs_n), .din(din), .self_term(self_term), .latch_a_code(a), .latch_b_code(b),
    .double_buffer_code(d), .fast_mode(fast), .power_down(pd), .update_pulse(upd));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (upd === 1'b1) pulses++;
    if (cycles == 3000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors %0d checked %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One frame, then enough idle time for the transfer to land; exactly one pulse
  task automatic frame(input logic [19:0] w, input int n, input logic st);
    int p0;
    @(negedge ref_clk);
    self_term = st;
    p0 = pulses;
    repeat (4) @(negedge ref_clk);
    host.send(w, n);
    repeat (12) @(negedge ref_clk);
    `CHK(pulses - p0, 1)
  endtask
  task automatic expect_out(input logic [11:0] ea, eb, ed, input logic ef, ep, input string nm);
    `CHK(a, ea)
    `CHK(b, eb)
    `CHK(d, ed)
    `CHK({fast, pd}, {ef, ep})
    $display("test %s done", nm);
  endtask
  task automatic test_b_write();
    frame(20'h04abc, 16, 1'b0);
    expect_out(12'h000, 12'habc, 12'habc, 1'b1, 1'b0, "b_write");
  endtask
  task automatic test_buf_only();
    frame(20'h05123, 16, 1'b0);
    expect_out(12'h000, 12'habc, 12'h123, 1'b1, 1'b0, "buf_only");
  endtask
  task automatic test_a_write();
    frame(20'h0a456, 16, 1'b0);
    expect_out(12'h456, 12'h123, 12'h123, 1'b0, 1'b1, "a_write");
  endtask
  task automatic test_idle_clocks();
    host.idle_clk(8);
    frame(20'h0009a, 8, 1'b1);
    expect_out(12'h456, 12'h123, 12'h69a, 1'b1, 1'b0, "idle_clocks");
  endtask
  task automatic test_plain_long();
    frame(20'hf4777, 20, 1'b0);
    expect_out(12'h456, 12'h777, 12'h777, 1'b1, 1'b0, "plain_long");
  endtask
  task automatic test_self_term();
    frame(20'h2888f, 20, 1'b1);
    expect_out(12'h456, 12'h888, 12'h888, 1'b0, 1'b1, "self_term");
  endtask
  initial begin
    reset = 1'b1;
    self_term = 1'b0;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    expect_out(12'h000, 12'h000, 12'h000, 1'b0, 1'b0, "reset");
    test_b_write();
    test_buf_only();
    test_a_write();
    test_idle_clocks();
    test_plain_long();
    test_self_term();
    stop_test();
  end
endmodule
`default_nettype wire
